// >>> design/uhc_host.v
`timescale 1ns/1ps
`include "uhc_defs.vh"

// Contract
// - Host stops making strobe edges within tRFS after device ready drops.
// - Host raises STOP within tLI of request drop, holds until termination.
// - Host raises a low strobe within tLI of request drop; device ignores it.
// - Host drives CRC, drops acknowledge after tMLI and tDVS.
// - Device-ended burst: host holds STOP, no host ready, for tACK after acknowledge.
// - Host-ended burst: host holds STOP and strobe for tACK after acknowledge.
// - Host asserts no write strobe, chip select or address until tACK after.
// - Host starts its own termination by ceasing strobe edges.
// - Host asserts STOP no sooner than tSS after last edge, holds till end.
// - With request and acknowledge both negated, the lines resume ordinary roles.
module uhc_host (
    input wire clk_i,
    input wire reset_i,
    input wire start_i,
    input wire term_i,
    input wire word_valid_i,
    input wire [15:0] word_data_i,
    output wire word_ready_o,
    input wire dmarq_i,
    input wire ddmardy_n_i,
    output wire dmack_n_o,
    output wire stop_o,
    output wire hstrobe_o,
    output wire [15:0] dd_o,
    output wire dd_oe_o,
    output wire busy_o,
    output wire pio_ok_o,
    output wire done_o,
    output wire dev_term_o,
    output wire [15:0] crc_o
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ARM = 3'h1;
    localparam [2:0] ST_ENV = 3'h2;
    localparam [2:0] ST_XFER = 3'h3;
    localparam [2:0] ST_HSS = 3'h4;
    localparam [2:0] ST_TERM = 3'h5;
    localparam [2:0] ST_ACKH = 3'h6;

    // Interval counts are reckoned in integers and cut to the counter width here.
    localparam integer ACK_I = `UHC_T_ACK_CYC;
    localparam integer SS_I = `UHC_T_SS_CYC;
    localparam integer MLI_I = `UHC_T_MLI_CYC;
    localparam integer DVS_I = `UHC_T_DVS_CYC;
    localparam integer DVH_I = `UHC_T_DVH_CYC;
    localparam integer CYC_I = `UHC_T_CYC_CYC;
    localparam [7:0] ACK_CYC = ACK_I[7:0];
    localparam [7:0] SS_CYC = SS_I[7:0];
    localparam [7:0] MLI_CYC = MLI_I[7:0];
    localparam [7:0] DVS_CYC = DVS_I[7:0];
    localparam [7:0] DVH_CYC = DVH_I[7:0];
    localparam [7:0] CYC_CYC = CYC_I[7:0];

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [7:0] cnt_ff;
    reg [7:0] nxt_cnt;
    reg [7:0] edge_cnt_ff;
    reg [7:0] nxt_edge_cnt;
    reg [7:0] ld_cnt_ff;
    reg [7:0] nxt_ld_cnt;
    reg loaded_ff;
    reg nxt_loaded;
    reg first_ff;
    reg nxt_first;
    reg term_req_ff;
    reg nxt_term_req;
    reg crc_on_ff;
    reg nxt_crc_on;
    reg dev_term_ff;
    reg nxt_dev_term;
    reg dmack_n_ff;
    reg nxt_dmack_n;
    reg stop_ff;
    reg nxt_stop;
    reg hstrobe_ff;
    reg nxt_hstrobe;
    reg dd_oe_ff;
    reg nxt_dd_oe;
    reg [15:0] dd_ff;
    reg [15:0] nxt_dd;
    reg [15:0] crc_ff;
    reg [15:0] nxt_crc;
    reg done_ff;
    reg nxt_done;
    reg edge_pulse;

    wire [1:0] sync_w;
    wire dmarq_s;
    wire rdy_s;
    wire [15:0] crc_next_w;

    uhc_sync u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({dmarq_i, ddmardy_n_i}),
        .sync_o(sync_w)
    );

    assign dmarq_s = sync_w[1];
    // Ready is active low on the cable; the logic below works with an active-high copy.
    assign rdy_s = ~sync_w[0];

    uhc_crc16 u_crc (
        .crc_i(crc_ff),
        .data_i(dd_ff),
        .crc_o(crc_next_w)
    );

    function [7:0] sat_inc;
        input [7:0] v;
        begin
            sat_inc = (v == `UHC_CNT_MAX) ? v : v + `UHC_CNT_ONE;
        end
    endfunction

    always @* begin
        nxt_state = state_ff;
        nxt_cnt = sat_inc(cnt_ff);
        nxt_edge_cnt = sat_inc(edge_cnt_ff);
        nxt_ld_cnt = sat_inc(ld_cnt_ff);
        nxt_loaded = loaded_ff;
        nxt_first = first_ff;
        nxt_term_req = term_req_ff | term_i;
        nxt_crc_on = crc_on_ff;
        nxt_dev_term = dev_term_ff;
        nxt_dmack_n = dmack_n_ff;
        nxt_stop = stop_ff;
        nxt_hstrobe = hstrobe_ff;
        nxt_dd_oe = dd_oe_ff;
        nxt_dd = dd_ff;
        nxt_crc = crc_ff;
        nxt_done = 1'b0;
        edge_pulse = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_term_req = 1'b0;
                // A start while the request is still low waits here until the device asks.
                if (start_i && dmarq_s) begin
                    nxt_state = ST_ARM;
                    nxt_stop = 1'b1;
                    nxt_hstrobe = 1'b1;
                    nxt_dd_oe = 1'b1;
                    nxt_crc = `UHC_CRC_SEED;
                    nxt_first = 1'b0;
                    nxt_loaded = 1'b0;
                    nxt_crc_on = 1'b0;
                    nxt_dev_term = 1'b0;
                    nxt_cnt = `UHC_CNT_ZERO;
                    nxt_edge_cnt = `UHC_CNT_MAX;
                end
            end
            ST_ARM: begin
                if (cnt_ff >= ACK_CYC) begin
                    nxt_dmack_n = 1'b0;
                    nxt_state = ST_ENV;
                end
            end
            ST_ENV: begin
                // STOP drops one cycle after acknowledge, well inside tENV.
                nxt_stop = 1'b0;
                nxt_state = ST_XFER;
            end
            ST_XFER: begin
                if (!dmarq_s) begin
                    // Device ended the burst: raise STOP and a low strobe at once.
                    nxt_stop = 1'b1;
                    nxt_hstrobe = 1'b1;
                    nxt_dev_term = 1'b1;
                    nxt_loaded = 1'b0;
                    // The tMLI count must start from STOP rising, not from an old idle count.
                    nxt_cnt = `UHC_CNT_ZERO;
                    nxt_state = ST_TERM;
                end else if (term_req_ff && first_ff) begin
                    // No further data edges from here on; only the strobe rise after the request drops remains.
                    nxt_loaded = 1'b0;
                    nxt_state = ST_HSS;
                end else begin
                    if (!loaded_ff && edge_cnt_ff >= DVH_CYC && word_valid_i) begin
                        nxt_dd = word_data_i;
                        nxt_loaded = 1'b1;
                        nxt_ld_cnt = `UHC_CNT_ZERO;
                    end
                    // A synchronised ready drop blocks the next edge, two cycles at most.
                    if (loaded_ff && rdy_s && edge_cnt_ff >= CYC_CYC && ld_cnt_ff >= DVS_CYC) begin
                        edge_pulse = 1'b1;
                        nxt_hstrobe = ~hstrobe_ff;
                        nxt_crc = crc_next_w;
                        nxt_edge_cnt = `UHC_CNT_ZERO;
                        nxt_loaded = 1'b0;
                        nxt_first = 1'b1;
                    end
                end
            end
            ST_HSS: begin
                if (edge_cnt_ff >= SS_CYC) begin
                    // Host-ended burst: STOP waits out tSS from the last strobe edge.
                    nxt_stop = 1'b1;
                    nxt_cnt = `UHC_CNT_ZERO;
                    nxt_state = ST_TERM;
                end
            end
            ST_TERM: begin
                // The strobe rise after the request drops carries no word and no CRC update.
                if (!dmarq_s && !hstrobe_ff) begin
                    nxt_hstrobe = 1'b1;
                end
                if (!crc_on_ff && edge_cnt_ff >= DVH_CYC) begin
                    nxt_dd = crc_ff;
                    nxt_crc_on = 1'b1;
                    nxt_ld_cnt = `UHC_CNT_ZERO;
                end
                if (!(hstrobe_ff && stop_ff && !dmarq_s && !rdy_s)) begin
                    nxt_cnt = `UHC_CNT_ZERO;
                end else if (cnt_ff >= MLI_CYC && crc_on_ff && ld_cnt_ff >= DVS_CYC) begin
                    nxt_dmack_n = 1'b1;
                    nxt_cnt = `UHC_CNT_ZERO;
                    nxt_state = ST_ACKH;
                end
            end
            ST_ACKH: begin
                // STOP and strobe hold through tACK in both termination cases.
                if (cnt_ff >= ACK_CYC) begin
                    nxt_stop = 1'b0;
                    nxt_hstrobe = 1'b0;
                    nxt_dd_oe = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= `UHC_CNT_ZERO;
            edge_cnt_ff <= `UHC_CNT_ZERO;
            ld_cnt_ff <= `UHC_CNT_ZERO;
            loaded_ff <= 1'b0;
            first_ff <= 1'b0;
            term_req_ff <= 1'b0;
            crc_on_ff <= 1'b0;
            dev_term_ff <= 1'b0;
            dmack_n_ff <= 1'b1;
            stop_ff <= 1'b0;
            hstrobe_ff <= 1'b0;
            dd_oe_ff <= 1'b0;
            dd_ff <= `UHC_CRC_RESET;
            crc_ff <= `UHC_CRC_RESET;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            edge_cnt_ff <= nxt_edge_cnt;
            ld_cnt_ff <= nxt_ld_cnt;
            loaded_ff <= nxt_loaded;
            first_ff <= nxt_first;
            term_req_ff <= nxt_term_req;
            crc_on_ff <= nxt_crc_on;
            dev_term_ff <= nxt_dev_term;
            dmack_n_ff <= nxt_dmack_n;
            stop_ff <= nxt_stop;
            hstrobe_ff <= nxt_hstrobe;
            dd_oe_ff <= nxt_dd_oe;
            dd_ff <= nxt_dd;
            crc_ff <= nxt_crc;
            done_ff <= nxt_done;
        end
    end

    // The user word counts as consumed in the cycle whose edge sends it.
    assign word_ready_o = edge_pulse;
    assign dmack_n_o = dmack_n_ff;
    assign stop_o = stop_ff;
    assign hstrobe_o = hstrobe_ff;
    assign dd_o = dd_ff;
    assign dd_oe_o = dd_oe_ff;
    assign busy_o = (state_ff != ST_IDLE);
    // Chip selects, address and write strobe stay off until tACK after acknowledge drops.
    assign pio_ok_o = (state_ff == ST_IDLE);
    assign done_o = done_ff;
    assign dev_term_o = dev_term_ff;
    assign crc_o = crc_ff;
endmodule

// >>> include/uhc_defs.vh
`ifndef UHC_DEFS_VH
`define UHC_DEFS_VH

// Core clock period in ns (100 MHz).
`define UHC_CLK_NS 10

// Least times, in ns; the cycle counts round up.
`define UHC_T_ACK_NS 20
`define UHC_T_SS_NS 50
`define UHC_T_MLI_NS 20
`define UHC_T_DVS_NS 20
`define UHC_T_DVH_NS 10
`define UHC_T_CYC_NS 60

// Longest times, in ns; the cycle counts round down, but never below one cycle.
`define UHC_T_ENV_NS 20
`define UHC_T_LI_NS 100
`define UHC_T_RFS_NS 60

`define UHC_CEIL_CYC(t) ((((t) + `UHC_CLK_NS - 1) / `UHC_CLK_NS) < 1 ? 1 : (((t) + `UHC_CLK_NS - 1) / `UHC_CLK_NS))
`define UHC_FLOOR_CYC(t) (((t) / `UHC_CLK_NS) < 1 ? 1 : ((t) / `UHC_CLK_NS))

`define UHC_T_ACK_CYC `UHC_CEIL_CYC(`UHC_T_ACK_NS)
`define UHC_T_SS_CYC `UHC_CEIL_CYC(`UHC_T_SS_NS)
`define UHC_T_MLI_CYC `UHC_CEIL_CYC(`UHC_T_MLI_NS)
`define UHC_T_DVS_CYC `UHC_CEIL_CYC(`UHC_T_DVS_NS)
`define UHC_T_DVH_CYC `UHC_CEIL_CYC(`UHC_T_DVH_NS)
`define UHC_T_CYC_CYC `UHC_CEIL_CYC(`UHC_T_CYC_NS)
`define UHC_T_ENV_CYC `UHC_FLOOR_CYC(`UHC_T_ENV_NS)
`define UHC_T_LI_CYC `UHC_FLOOR_CYC(`UHC_T_LI_NS)
`define UHC_T_RFS_CYC `UHC_FLOOR_CYC(`UHC_T_RFS_NS)

// Transfer check code: seed and generator polynomial.
`define UHC_CRC_SEED 16'h4abb
`define UHC_CRC_POLY 16'h1021
`define UHC_CRC_RESET 16'h0000

// Synchroniser reset level: request low, active-low ready negated.
`define UHC_SYNC_RST 2'h1

`define UHC_WORD_W 16
`define UHC_CNT_W 8
`define UHC_CNT_ZERO 8'h00
`define UHC_CNT_ONE 8'h01
`define UHC_CNT_MAX 8'hff

`endif

// >>> design/uhc_sync.v
`timescale 1ns/1ps
`include "uhc_defs.vh"

module uhc_sync (
    input wire clk_i,
    input wire reset_i,
    input wire [1:0] async_i,
    output wire [1:0] sync_o
);
    reg [1:0] meta_ff;
    reg [1:0] sync_ff;

    // Reset leaves both stages at the idle level of the device's lines.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_ff <= `UHC_SYNC_RST;
            sync_ff <= `UHC_SYNC_RST;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// >>> design/uhc_crc16.v
`timescale 1ns/1ps
`include "uhc_defs.vh"

module uhc_crc16 (
    input wire [15:0] crc_i,
    input wire [15:0] data_i,
    output reg [15:0] crc_o
);
    integer i;
    reg fb;

    // One word per call, most significant bit first.
    always @* begin
        crc_o = crc_i;
        fb = 1'b0;
        for (i = 15; i >= 0; i = i - 1) begin
            fb = crc_o[15] ^ data_i[i];
            crc_o = {crc_o[14:0], 1'b0};
            if (fb) begin
                crc_o = crc_o ^ `UHC_CRC_POLY;
            end
        end
    end
endmodule

// >>> verif/uhc_host_asserts.sv
`timescale 1ns/1ps
`include "uhc_defs.vh"
module uhc_host_asserts (
    input wire clk_i,
    input wire reset_i,
    input wire dmarq_i,
    input wire ddmardy_n_i,
    input wire dmack_n_o,
    input wire stop_o,
    input wire hstrobe_o,
    input wire [15:0] dd_o,
    input wire dd_oe_o,
    input wire pio_ok_o,
    input wire [15:0] crc_o
);
    localparam int LI = `UHC_T_LI_CYC;
    localparam int ACK = `UHC_T_ACK_CYC;
    localparam int ACKX = ACK + 2;
    localparam int SS = `UHC_T_SS_CYC;
    localparam int RFS = `UHC_T_RFS_CYC;
    logic hs_ff;
    logic [7:0] gap_ff;
    wire quiet_w = stop_o && hstrobe_o && !dmarq_i && ddmardy_n_i;
    // Cycles since the last strobe edge, saturating so a long idle never wraps.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hs_ff <= 1'b0;
            gap_ff <= 8'h00;
        end else begin
            hs_ff <= hstrobe_o;
            gap_ff <= (hstrobe_o != hs_ff) ? 8'h00 : ((gap_ff == 8'hff) ? gap_ff : gap_ff + 8'h01);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence rq_drop; $fell(dmarq_i) && !dmack_n_o; endsequence
    sequence ack_off; $rose(dmack_n_o); endsequence
    sequence rdy_drop; $rose(ddmardy_n_i) && !dmack_n_o; endsequence
    a_rfs_quiet: assert property (rdy_drop |-> ##RFS
        (!$changed(hstrobe_o) || !$past(dmarq_i, 2) || dmack_n_o) [*4]) else $error("strobe moves late");
    a_stop_on_drop: assert property (rq_drop |-> ##[0:LI] stop_o) else $error("stop late");
    a_strobe_up: assert property (rq_drop |-> ##[0:LI] hstrobe_o) else $error("strobe not raised");
    a_mli_wait: assert property (ack_off |-> $past(quiet_w, 2)) else $error("ack dropped early");
    a_crc_held: assert property (ack_off |->
        dd_oe_o && dd_o == crc_o && $stable(dd_o) && $past(dd_o, 2) == dd_o) else $error("crc not held");
    a_ack_hold: assert property (ack_off |-> (stop_o && hstrobe_o && !pio_ok_o) [*2])
        else $error("lines freed before ack time");
    a_bus_free: assert property (ack_off |-> ##[ACK:ACKX] (!stop_o && !hstrobe_o && !dd_oe_o && pio_ok_o))
        else $error("lines not returned");
    a_ss_gap: assert property ($rose(stop_o) && !dmack_n_o && dmarq_i |-> gap_ff >= SS)
        else $error("stop too soon after edge");
endmodule
bind uhc_host uhc_host_asserts i_chk (.clk_i(clk_i), .reset_i(reset_i), .dmarq_i(dmarq_i),
    .ddmardy_n_i(ddmardy_n_i), .dmack_n_o(dmack_n_o), .stop_o(stop_o), .hstrobe_o(hstrobe_o),
    .dd_o(dd_o), .dd_oe_o(dd_oe_o), .pio_ok_o(pio_ok_o), .crc_o(crc_o));

// >>> verif/uhc_dev_model.sv
`timescale 1ns/1ps
module uhc_dev_model #(parameter int RP = 4) (
    input wire clk_i,
    input wire reset_i,
    input wire go_i,
    input wire dterm_i,
    input wire slow_i,
    input wire dmack_n_i,
    input wire stop_i,
    input wire hstrobe_i,
    input wire [15:0] dd_i,
    output logic dmarq_o,
    output logic ddmardy_n_o,
    output logic got_o,
    output logic [15:0] word_o,
    output logic [15:0] crc_cap_o
);
    logic [2:0] st_ff;
    logic [3:0] cnt_ff, n_ff;
    logic hs_ff, ack_ff;
    // Words still count after ready drops, but not once the request is down.
    wire take_w = hstrobe_i != hs_ff && !dmack_n_i && dmarq_o && st_ff[1];
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            {st_ff, cnt_ff, n_ff, hs_ff, ack_ff, dmarq_o, ddmardy_n_o, got_o} <= 16'h000a;
            word_o <= 16'h0000;
            crc_cap_o <= 16'h0000;
        end else begin
            hs_ff <= hstrobe_i;
            ack_ff <= dmack_n_i;
            got_o <= take_w;
            if (take_w) begin
                word_o <= dd_i;
                n_ff <= n_ff + 4'h1;
            end
            case (st_ff)
                3'd0: if (go_i) begin
                    dmarq_o <= 1'b1;
                    n_ff <= 4'h0;
                    cnt_ff <= 4'h0;
                    st_ff <= 3'd1;
                end
                3'd1: if (!dmack_n_i) begin
                    ddmardy_n_o <= 1'b0;
                    st_ff <= 3'd2;
                end
                3'd2: if (stop_i) begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff >= (slow_i ? 4'h6 : 4'h0)) begin
                        {dmarq_o, ddmardy_n_o, cnt_ff, st_ff} <= {2'b01, 4'h0, 3'd4};
                    end
                end else if (dterm_i && n_ff != 4'h0) begin
                    {ddmardy_n_o, cnt_ff, st_ff} <= {1'b1, 4'h0, 3'd3};
                end
                3'd3: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff >= RP + (slow_i ? 4 : 0)) begin
                        dmarq_o <= 1'b0;
                        st_ff <= 3'd4;
                    end
                end
                // Ready stays negated from here on, which also serves as its release.
                default: if (dmack_n_i && !ack_ff) begin
                    crc_cap_o <= dd_i;
                    st_ff <= 3'd0;
                end
            endcase
        end
    end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`include "uhc_defs.vh"
module tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic term_i = 1'b0;
    logic word_valid_i = 1'b0;
    logic [15:0] word_data_i = 16'h0000;
    logic go = 1'b0;
    logic dterm = 1'b0;
    logic slow = 1'b0;
    logic [15:0] crc_exp;
    logic [15:0] q[$];
    int err_total = 0;
    int cmp_count = 0;
    wire dmarq, rdy_n, wrdy, dmack_n, stop, hs, oe, busy, done, dev_term, got;
    wire [15:0] dd, word, crc_cap;
    // Undriven data lines show the inverse, so a stale value never passes.
    wire [15:0] bus = oe ? dd : ~dd;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    uhc_host i_dut (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .term_i(term_i),
        .word_valid_i(word_valid_i), .word_data_i(word_data_i), .word_ready_o(wrdy), .dmarq_i(dmarq),
        .ddmardy_n_i(rdy_n), .dmack_n_o(dmack_n), .stop_o(stop), .hstrobe_o(hs), .dd_o(dd), .dd_oe_o(oe),
        .busy_o(busy), .pio_ok_o(), .done_o(done), .dev_term_o(dev_term), .crc_o());
    uhc_dev_model i_dev (.clk_i(clk_i), .reset_i(reset_i), .go_i(go), .dterm_i(dterm), .slow_i(slow),
        .dmack_n_i(dmack_n), .stop_i(stop), .hstrobe_i(hs), .dd_i(bus), .dmarq_o(dmarq),
        .ddmardy_n_o(rdy_n), .got_o(got), .word_o(word), .crc_cap_o(crc_cap));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `UHC_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction
    task automatic conclude;
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (got === 1'b1) begin
            chk(word, q.size() > 0 ? q.pop_front() : ~word);
        end
    end
    task automatic burst(input logic host, input int n);
        int k;
        logic fin, nd, sent;
        k = 0;
        fin = 1'b0;
        sent = 1'b0;
        crc_exp = `UHC_CRC_SEED;
        @(posedge clk_i);
        #1;
        {go, start_i, word_valid_i} = 3'b111;
        slow = 1'($urandom_range(1));
        word_data_i = 16'($urandom);
        for (int c = 0; c < 3000 && !fin; c++) begin
            @(negedge clk_i);
            nd = (wrdy === 1'b1);
            fin = (done === 1'b1);
            if (nd) begin
                q.push_back(word_data_i);
                crc_exp = crc_step(crc_exp, word_data_i);
                k++;
            end
            @(posedge clk_i);
            #1;
            go = 1'b0;
            if (busy === 1'b1) start_i = 1'b0;
            if (nd) word_data_i = 16'($urandom);
            term_i = host && k >= n && !sent;
            sent = sent | term_i;
            dterm = !host && k >= n;
        end
        {start_i, term_i, word_valid_i, dterm} = 4'h0;
        chk({15'h0, fin}, 16'h0001);
        repeat (4) @(posedge clk_i);
        chk(crc_cap, crc_exp);
        chk(16'(q.size()), 16'h0000);
        chk({15'h0, dev_term}, {15'h0, !host});
        $display("test done: host=%0d words=%0d", host, k);
    endtask
    initial begin
        void'($urandom(32'hf74ed6d1));
        repeat (5) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        repeat (3) @(posedge clk_i);
        burst(1'b0, 0);
        for (int t = 0; t < 6; t++) begin
            burst(t[0], 1 + $urandom_range(4));
        end
        conclude();
    end
    initial begin
        #200000;
        err_total++;
        conclude();
    end
endmodule
